// file: logic/spcs_pcs_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Transmit reset outside bypass sends negative comma, ignores inputs
// - After reset: negative disparity, three commas
// - Filler words precede sync commas after reset
// - Running disparity tracked, commas alternate forms
// - Force input overrides disparity for one group
// - Low latency bypasses coding and rate match
// - Electrical idle turns the line driver off
// - Signal detect reported only with coding on
// - Rate match absorbs 200 ppm total offset
// - Rate match idle until sync status high
// - Insert or delete whole second idle sets
// - Odd removal rounds up to whole sets
// - Autonegotiation config pairs also matched
// - Delete and insert flags two cycles each
module spcs_pcs_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cfg_low_latency,
	input wire logic cfg_gige,
	input wire logic tx_dig_rst,
	input wire logic [7:0] tx_data,
	input wire logic tx_is_k,
	input wire logic [spcs_pkg::WORD_W-1:0] tx_raw,
	input wire logic tx_force_disp,
	input wire logic tx_disp_val,
	input wire logic tx_elec_idle,
	output logic tx_accept,
	output logic [spcs_pkg::WORD_W-1:0] tx_code,
	output logic tx_drv_oe,
	input wire logic rx_sig_det_in,
	output logic rx_sig_det,
	input wire logic rx_sync_status,
	input wire logic rx_autoneg,
	input wire logic rx_in_valid,
	input wire logic [spcs_pkg::WORD_W-1:0] rx_in_word,
	output logic rx_in_ready,
	output logic rx_out_valid,
	input wire logic rx_out_ready,
	output logic [spcs_pkg::WORD_W-1:0] rx_out_word,
	output logic rx_rm_deleted,
	output logic rx_rm_inserted
);
	import spcs_pkg::*;

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// Transmit side state
	spcs_tx_state_type state_q;
	logic [1:0] cnt_q;
	logic rd_q;
	logic [WORD_W-1:0] tx_code_q;
	logic tx_drv_oe_q;
	logic [7:0] enc_data;
	logic enc_k;
	logic enc_rd;
	logic [9:0] enc_code;
	logic enc_rd_out;

	// Receive side state
	logic rm_en;
	logic hold_v_q;
	logic [WORD_W-1:0] hold_q;
	logic del;
	logic [LW-1:0] level;
	logic out_valid_q;
	logic [WORD_W-1:0] out_word_q;
	logic adv;
	logic last_comma_q;
	logic [1:0] ins_cnt_q;
	logic [WORD_W-1:0] ins_sec_q;
	logic fifo_take;
	logic ins_go;
	logic [2:0] del_cnt_q;
	logic [2:0] ins_flag_q;

	spcs_stream_if #(.W(WORD_W)) fifo_in ();
	spcs_stream_if #(.W(WORD_W)) fifo_out ();

	// Idle-set recognisers on receive words
	function automatic logic is_comma(input logic [WORD_W-1:0] w);
		return w[RX_K_BIT] && w[7:0] == K28_5;
	endfunction : is_comma

	function automatic logic is_second(input logic [WORD_W-1:0] w,
		input logic an);
		return !w[RX_K_BIT] &&
			(w[7:0] == D16_2 || (an && w[7:0] == D2_2));
	endfunction : is_second

	// ---------------- transmit ----------------

	// Sequencer: reset, pipeline fill, three commas, then data
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= TX_RST;
		end else if (tx_dig_rst) begin
			state_q <= TX_RST;
		end else begin
			case (state_q)
				TX_RST: begin
					state_q <= TX_LAT;
				end
				TX_LAT: begin
					if (cnt_q == PIPE_LAT - 2'h1) begin
						state_q <= TX_SYNC;
					end
				end
				TX_SYNC: begin
					if (cnt_q == SYNC_COMMAS - 2'h1) begin
						state_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					state_q <= TX_DATA;
				end
				default: begin
					state_q <= TX_RST;
				end
			endcase
		end
	end

	// Shared step counter for fill words and sync commas
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 2'h0;
		end else if (tx_dig_rst || state_q == TX_RST) begin
			cnt_q <= 2'h0;
		end else if (state_q == TX_LAT) begin
			cnt_q <= (cnt_q == PIPE_LAT - 2'h1) ? 2'h0 : cnt_q + 2'h1;
		end else if (state_q == TX_SYNC) begin
			cnt_q <= cnt_q + 2'h1;
		end
	end

	// Encoder feed; the force pins act only on user groups
	always_comb begin
		enc_data = K28_5;
		enc_k = 1'b1;
		enc_rd = rd_q;
		if (state_q == TX_DATA) begin
			enc_data = tx_data;
			enc_k = tx_is_k;
			if (tx_force_disp) begin
				enc_rd = !tx_disp_val;
			end
		end
	end

	spcs_enc8b10b u_enc (
		.data(enc_data),
		.is_k(enc_k),
		.rd_in(enc_rd),
		.code(enc_code),
		.rd_out(enc_rd_out)
	);

	// Running disparity restarts negative at every reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_q <= RD_NEG;
		end else if (cfg_low_latency || tx_dig_rst) begin
			rd_q <= RD_NEG;
		end else if (state_q == TX_RST || state_q == TX_LAT) begin
			rd_q <= RD_NEG;
		end else begin
			rd_q <= enc_rd_out;
		end
	end

	// Output word; bypass passes the raw fabric word through
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_code_q <= K28_5_NEG;
		end else if (cfg_low_latency) begin
			tx_code_q <= tx_raw;
		end else if (tx_dig_rst || state_q == TX_RST) begin
			tx_code_q <= K28_5_NEG;
		end else if (state_q == TX_LAT) begin
			tx_code_q <= TX_FILL;
		end else begin
			tx_code_q <= enc_code;
		end
	end

	// Driver off in electrical idle; line floats at common mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_drv_oe_q <= 1'b0;
		end else begin
			tx_drv_oe_q <= !tx_elec_idle;
		end
	end

	// Fabric data is taken once sync commas are out, or at once in bypass
	assign tx_accept = !tx_dig_rst &&
		(cfg_low_latency || state_q == TX_DATA);
	assign tx_code = tx_code_q;
	assign tx_drv_oe = tx_drv_oe_q;

	// Detect only meaningful with the coding stage in the path
	assign rx_sig_det = rx_sig_det_in && !cfg_low_latency;

	// ---------------- receive ----------------

	// Matching waits for word sync and is off in bypass
	assign rm_en = cfg_gige && rx_sync_status && !cfg_low_latency;

	assign adv = !out_valid_q || rx_out_ready;

	// Hold stage lets a comma be judged with its follower
	assign rx_in_ready = cfg_low_latency ? adv :
		(!hold_v_q || fifo_in.ready);

	// Whole-set deletion only; a half set is never dropped
	assign del = rm_en && rx_in_valid && rx_in_ready && hold_v_q &&
		is_comma(hold_q) && is_second(rx_in_word, rx_autoneg) &&
		level >= LW'(RM_HI);

	assign fifo_in.valid = !cfg_low_latency && hold_v_q &&
		rx_in_valid && !del;
	assign fifo_in.data = hold_q;

	// One-word hold ahead of the buffer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hold_v_q <= 1'b0;
			hold_q <= '0;
		end else if (cfg_low_latency) begin
			hold_v_q <= 1'b0;
		end else if (del) begin
			hold_v_q <= 1'b0;
		end else if (rx_in_valid && rx_in_ready) begin
			hold_v_q <= 1'b1;
			hold_q <= rx_in_word;
		end
	end

	spcs_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr(fifo_in),
		.rd(fifo_out),
		.level(level)
	);

	// Buffer is read only when no inserted set is being emitted
	assign fifo_take = adv && !cfg_low_latency && ins_cnt_q == 2'h0;
	assign fifo_out.ready = fifo_take;

	// Insert after a completed set while the buffer runs low
	assign ins_go = rm_en && fifo_take && fifo_out.valid &&
		last_comma_q && is_second(fifo_out.data, rx_autoneg) &&
		level <= LW'(RM_LO);

	// Output register: bypass, inserted pair, or buffer word
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			out_valid_q <= 1'b0;
			out_word_q <= '0;
		end else if (adv) begin
			if (cfg_low_latency) begin
				out_valid_q <= rx_in_valid;
				out_word_q <= rx_in_word;
			end else if (ins_cnt_q == 2'h2) begin
				out_valid_q <= 1'b1;
				out_word_q <= {2'h1, K28_5};
			end else if (ins_cnt_q == 2'h1) begin
				out_valid_q <= 1'b1;
				out_word_q <= ins_sec_q;
			end else begin
				out_valid_q <= fifo_out.valid;
				out_word_q <= fifo_out.data;
			end
		end
	end

	// Remember whether the last word sent was a comma
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			last_comma_q <= 1'b0;
		end else if (adv && !cfg_low_latency) begin
			if (ins_cnt_q != 2'h0) begin
				last_comma_q <= ins_cnt_q == 2'h2;
			end else if (fifo_out.valid) begin
				last_comma_q <= is_comma(fifo_out.data);
			end
		end
	end

	// Inserted set counts down comma then second symbol
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ins_cnt_q <= 2'h0;
			ins_sec_q <= '0;
		end else if (cfg_low_latency) begin
			ins_cnt_q <= 2'h0;
		end else if (ins_go) begin
			ins_cnt_q <= 2'h2;
			ins_sec_q <= fifo_out.data;
		end else if (adv && ins_cnt_q != 2'h0) begin
			ins_cnt_q <= ins_cnt_q - 2'h1;
		end
	end

	// Flags stretch two cycles per set; back-to-back sets add up
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			del_cnt_q <= 3'h0;
		end else if (del) begin
			del_cnt_q <= del_cnt_q + FLAG_CYC - {2'h0, |del_cnt_q};
		end else if (del_cnt_q != 3'h0) begin
			del_cnt_q <= del_cnt_q - 3'h1;
		end
	end

	// Insert flag counts time, not output handshakes
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ins_flag_q <= 3'h0;
		end else if (ins_go) begin
			ins_flag_q <= ins_flag_q + FLAG_CYC - {2'h0, |ins_flag_q};
		end else if (ins_flag_q != 3'h0) begin
			ins_flag_q <= ins_flag_q - 3'h1;
		end
	end

	assign rx_out_valid = out_valid_q;
	assign rx_out_word = out_word_q;
	assign rx_rm_deleted = del_cnt_q != 3'h0;
	assign rx_rm_inserted = ins_flag_q != 3'h0;
endmodule : spcs_pcs_top

// file: logic/spcs_pkg.sv
package spcs_pkg;
	// Symbol values, control flag in bit 8 of a receive word
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] D16_2 = 8'h50;
	localparam logic [7:0] D2_2 = 8'h42;
	localparam int WORD_W = 10;
	localparam int RX_K_BIT = 8;
	// Negative-disparity comma and the filler sent during pipeline fill
	localparam logic [9:0] K28_5_NEG = 10'h00FA;
	localparam logic [9:0] TX_FILL = 10'h0000;
	localparam logic RD_NEG = 1'b0;
	// Sequence counts
	localparam logic [1:0] SYNC_COMMAS = 2'h3;
	localparam logic [1:0] PIPE_LAT = 2'h2;
	localparam logic [2:0] FLAG_CYC = 3'h2;
	// Rate match: 32 words cover 200 ppm over long frames with margin
	localparam int PPM_TOTAL = 200;
	localparam int FIFO_DEPTH = 32;
	localparam int RM_HI = 24;
	localparam int RM_LO = 8;
	// Transmit sequencer, Gray coded along reset-fill-sync-data
	typedef enum logic [1:0] {
		TX_RST = 2'h0,
		TX_LAT = 2'h1,
		TX_SYNC = 2'h3,
		TX_DATA = 2'h2
	} spcs_tx_state_type;
endpackage : spcs_pkg

// file: logic/spcs_stream_if.sv
`timescale 1ns/100ps
// Valid/ready word stream between the block's own modules
interface spcs_stream_if #(parameter int W = 10) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : spcs_stream_if

// file: logic/spcs_fifo.sv
`timescale 1ns/100ps
module spcs_fifo #(
	parameter int W = 10,
	parameter int D = 32,
	parameter int AW = $clog2(D)
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	spcs_stream_if.snk wr,
	spcs_stream_if.src rd,
	output logic [AW:0] level
);
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Depth must be a power of two so pointers wrap by themselves
	assign wr.ready = cnt_q != (AW+1)'(D);
	assign rd.valid = cnt_q != '0;
	assign rd.data = mem_q[rp_q];
	assign level = cnt_q;
	assign push = wr.valid & wr.ready;
	assign pop = rd.valid & rd.ready;

	// Storage needs no reset, the count guards it
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wp_q] <= wr.data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : spcs_fifo

// file: logic/spcs_enc8b10b.sv
`timescale 1ns/100ps
module spcs_enc8b10b (
	input wire logic [7:0] data,
	input wire logic is_k,
	input wire logic rd_in,
	output logic [9:0] code,
	output logic rd_out
);
	// Negative-disparity forms, 5b/6b then 3b/4b
	localparam logic [5:0] T6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4D [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] T4K [8] = '{
		4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
	logic [4:0] x;
	logic [2:0] y;
	logic [5:0] s6;
	logic [3:0] f4;
	logic rd1;
	logic alt;

	assign x = data[4:0];
	assign y = data[7:5];

	// Control groups invert whole; data groups per sub-block
	always_comb begin
		s6 = (is_k && x == 5'h1C) ? 6'h0F : T6[x];
		f4 = is_k ? T4K[y] : T4D[y];
		rd1 = rd_in ^ ($countones(s6) != 3);
		alt = y == 3'h7 && ((!rd1 && (x == 5'h11 || x == 5'h12 ||
			x == 5'h14)) || (rd1 && (x == 5'h0B || x == 5'h0D ||
			x == 5'h0E)));
		if (is_k) begin
			code = rd_in ? ~{s6, f4} : {s6, f4};
			rd_out = rd_in ^ ($countones({s6, f4}) != 5);
		end else begin
			if (rd_in && ($countones(s6) != 3 || x == 5'h07)) begin
				s6 = ~s6;
			end
			if (alt) begin
				f4 = 4'h7;
			end
			if (rd1 && ($countones(f4) != 2 || y == 3'h3)) begin
				f4 = ~f4;
			end
			code = {s6, f4};
			rd_out = rd1 ^ ($countones(f4) != 2);
		end
	end
endmodule : spcs_enc8b10b

// file: verif/spcs_checker.sv
`timescale 1ns/100ps
// Timing relations seen at the top ports
module spcs_checker (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cfg_low_latency,
	input wire logic tx_dig_rst,
	input wire logic [7:0] tx_data,
	input wire logic tx_is_k,
	input wire logic [spcs_pkg::WORD_W-1:0] tx_raw,
	input wire logic tx_force_disp,
	input wire logic tx_disp_val,
	input wire logic tx_elec_idle,
	input wire logic tx_accept,
	input wire logic [spcs_pkg::WORD_W-1:0] tx_code,
	input wire logic tx_drv_oe,
	input wire logic rx_sig_det_in,
	input wire logic rx_sig_det,
	input wire logic rx_sync_status,
	input wire logic rx_rm_deleted,
	input wire logic rx_rm_inserted
);
	import spcs_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// Comma taken by the encoder in coded mode
	wire comma_take = tx_accept && tx_is_k && tx_data == K28_5 &&
		!cfg_low_latency;
	property p_rst_comma;
		tx_dig_rst && !cfg_low_latency |=> tx_code == K28_5_NEG;
	endproperty
	a_rst_comma: assert property (p_rst_comma) else $error("no reset comma");
	property p_rst_hold;
		tx_dig_rst && !cfg_low_latency |-> !tx_accept;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("taken in reset");
	property p_sync;
		$fell(tx_dig_rst) && !cfg_low_latency |-> ##[1:5]
		(tx_code == K28_5_NEG ##1 tx_code == 10'h0305 ##1
		tx_code == K28_5_NEG && tx_accept);
	endproperty
	a_sync: assert property (p_sync) else $error("bad sync burst");
	property p_alt;
		comma_take && !tx_force_disp ##1 comma_take && !tx_force_disp
		|=> tx_code != $past(tx_code);
	endproperty
	a_alt: assert property (p_alt) else $error("no alternation");
	property p_force;
		comma_take && tx_force_disp |=>
		tx_code == ($past(tx_disp_val) ? K28_5_NEG : 10'h0305);
	endproperty
	a_force: assert property (p_force) else $error("force ignored");
	property p_bypass;
		cfg_low_latency && tx_accept |=> tx_code == $past(tx_raw);
	endproperty
	a_bypass: assert property (p_bypass) else $error("raw not passed");
	property p_idle;
		1'b1 |=> tx_drv_oe == !$past(tx_elec_idle);
	endproperty
	a_idle: assert property (p_idle) else $error("driver enable wrong");
	property p_sigdet;
		rx_sig_det == (rx_sig_det_in && !cfg_low_latency);
	endproperty
	a_sigdet: assert property (p_sigdet) else $error("detect wrong");
	property p_nosync;
		!rx_sync_status [*3] |-> !rx_rm_deleted && !rx_rm_inserted;
	endproperty
	a_nosync: assert property (p_nosync) else $error("match unsynced");
	property p_del2;
		$rose(rx_rm_deleted) |=> rx_rm_deleted;
	endproperty
	a_del2: assert property (p_del2) else $error("short delete flag");
	property p_ins2;
		$rose(rx_rm_inserted) |=> rx_rm_inserted;
	endproperty
	a_ins2: assert property (p_ins2) else $error("short insert flag");
	c_force: cover property (comma_take && tx_force_disp);
	c_del: cover property ($rose(rx_rm_deleted));
	c_ins: cover property ($rose(rx_rm_inserted));
endmodule : spcs_checker
bind spcs_pcs_top spcs_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.cfg_low_latency(cfg_low_latency), .tx_dig_rst(tx_dig_rst),
	.tx_data(tx_data), .tx_is_k(tx_is_k), .tx_raw(tx_raw),
	.tx_force_disp(tx_force_disp), .tx_disp_val(tx_disp_val),
	.tx_elec_idle(tx_elec_idle), .tx_accept(tx_accept),
	.tx_code(tx_code), .tx_drv_oe(tx_drv_oe),
	.rx_sig_det_in(rx_sig_det_in), .rx_sig_det(rx_sig_det),
	.rx_sync_status(rx_sync_status), .rx_rm_deleted(rx_rm_deleted),
	.rx_rm_inserted(rx_rm_inserted));

// file: verif/spcs_far_model.sv
`timescale 1ns/100ps
// Far transceiver: sends idle sets, drains output, checks pairing
module spcs_far_model (
	input wire logic clk_sys,
	input wire logic [1:0] mode, // 0 off, 1 fast, 2 one word in five
	input wire logic [7:0] sec,
	input wire logic sink_stall,
	output logic rx_in_valid,
	output logic [spcs_pkg::WORD_W-1:0] rx_in_word,
	input wire logic rx_in_ready,
	input wire logic rx_out_valid,
	input wire logic [spcs_pkg::WORD_W-1:0] rx_out_word,
	output logic rx_out_ready,
	output int pair_errs
);
	import spcs_pkg::*;
	logic odd_q = 1'b0;
	logic want_q = 1'b0;
	logic [1:0] gap_q = 2'h0;
	initial rx_in_valid = 1'b0;
	initial rx_in_word = 10'h0000;
	initial pair_errs = 0;
	assign rx_out_ready = !sink_stall;
	// Held until taken; released word inverted so stale data never passes
	always @(posedge clk_sys) begin
		if (rx_in_valid && rx_in_ready) begin
			odd_q <= !odd_q;
			rx_in_valid <= 1'b0;
			rx_in_word <= ~rx_in_word;
			gap_q <= 2'h0;
		end else if (!rx_in_valid && mode != 2'h0) begin
			gap_q <= gap_q + 2'h1;
			if (mode == 2'h1 || gap_q == 2'h3) begin
				rx_in_valid <= 1'b1;
				rx_in_word <= odd_q ? {2'b00, sec} : {2'b01, K28_5};
			end
		end
	end
	// Output must stay in whole comma plus second pairs, commas exact
	always @(posedge clk_sys) begin
		if (rx_out_valid && rx_out_ready) begin
			if (want_q == rx_out_word[RX_K_BIT] ||
				(rx_out_word[RX_K_BIT] && rx_out_word != {2'b01, K28_5}))
				pair_errs <= pair_errs + 1;
			want_q <= rx_out_word[RX_K_BIT];
		end
	end
endmodule : spcs_far_model

// file: verif/spcs_pcs_top_bench.sv
`timescale 1ns/100ps
// Self-checking bench for coding, line control and rate match
module spcs_pcs_top_bench;
	import spcs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic cfg_low_latency = 1'b0;
	logic cfg_gige = 1'b1;
	logic tx_dig_rst = 1'b1;
	logic [7:0] tx_data = 8'hFF;
	logic tx_is_k = 1'b1;
	logic [9:0] tx_raw = 10'h0000;
	logic tx_force_disp = 1'b0;
	logic tx_disp_val = 1'b0;
	logic tx_elec_idle = 1'b0;
	logic rx_sig_det_in = 1'b0;
	logic rx_sync_status = 1'b0;
	logic rx_autoneg = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] sec = D16_2;
	logic sink_stall = 1'b0;
	logic tx_accept, tx_drv_oe, rx_sig_det, rx_in_valid, rx_in_ready;
	logic rx_out_valid, rx_out_ready, rx_rm_deleted, rx_rm_inserted;
	logic [9:0] tx_code, rx_in_word, rx_out_word;
	logic rd;
	int pair_errs;
	int num_errors = 0;
	int samples_checked = 0;
	spcs_pcs_top uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.cfg_low_latency(cfg_low_latency), .cfg_gige(cfg_gige),
		.tx_dig_rst(tx_dig_rst), .tx_data(tx_data), .tx_is_k(tx_is_k),
		.tx_raw(tx_raw), .tx_force_disp(tx_force_disp),
		.tx_disp_val(tx_disp_val), .tx_elec_idle(tx_elec_idle),
		.tx_accept(tx_accept), .tx_code(tx_code), .tx_drv_oe(tx_drv_oe),
		.rx_sig_det_in(rx_sig_det_in), .rx_sig_det(rx_sig_det),
		.rx_sync_status(rx_sync_status), .rx_autoneg(rx_autoneg),
		.rx_in_valid(rx_in_valid), .rx_in_word(rx_in_word),
		.rx_in_ready(rx_in_ready), .rx_out_valid(rx_out_valid),
		.rx_out_ready(rx_out_ready), .rx_out_word(rx_out_word),
		.rx_rm_deleted(rx_rm_deleted), .rx_rm_inserted(rx_rm_inserted));
	spcs_far_model u_far (.clk_sys(clk_sys), .mode(mode), .sec(sec),
		.sink_stall(sink_stall), .rx_in_valid(rx_in_valid),
		.rx_in_word(rx_in_word), .rx_in_ready(rx_in_ready),
		.rx_out_valid(rx_out_valid), .rx_out_word(rx_out_word),
		.rx_out_ready(rx_out_ready), .pair_errs(pair_errs));
	// 20 MHz clock
	initial forever #25 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [9:0] exp,
		input logic [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : check
	// Drive one symbol, check its code one edge after it is taken
	task automatic send(input logic k, input logic f, input logic v);
		logic [9:0] exp;
		tx_is_k = k;
		tx_data = k ? K28_5 : 8'hC5;
		tx_force_disp = f;
		tx_disp_val = v;
		@(negedge clk_sys);
		if (!k)
			exp = 10'h0296; // Neutral data symbol, disparity kept
		else if (f)
			exp = v ? K28_5_NEG : 10'h0305;
		else
			exp = rd ? 10'h0305 : K28_5_NEG;
		if (k)
			rd = f ? v : !rd;
		check("tx code", exp, tx_code);
	endtask : send
	task automatic t_sync;
		logic [39:0] hist;
		int n;
		repeat (3) begin
			@(negedge clk_sys);
			tx_data = ~tx_data;
			check("reset code", K28_5_NEG, tx_code);
			check("reset accept", 1'b0, tx_accept);
		end
		tx_dig_rst = 1'b0;
		n = 0;
		do begin
			@(negedge clk_sys);
			hist = {hist[29:0], tx_code};
			n++;
		end while (tx_accept !== 1'b1 && n < 12);
		check("fill", TX_FILL, hist[39:30]);
		check("comma 1", K28_5_NEG, hist[29:20]);
		check("comma 2", 10'h0305, hist[19:10]);
		check("comma 3", K28_5_NEG, hist[9:0]);
		$display("test sync done");
	endtask : t_sync
	// One data word then commas, forced against the tracked value
	task automatic t_disp;
		rd = 1'b1;
		send(1'b0, 1'b0, 1'b0);
		send(1'b1, 1'b0, 1'b0);
		send(1'b1, 1'b1, 1'b0);
		send(1'b1, 1'b0, 1'b0);
		send(1'b1, 1'b1, 1'b1);
		send(1'b1, 1'b0, 1'b0);
		$display("test disparity done");
	endtask : t_disp
	task automatic t_line;
		tx_elec_idle = 1'b1;
		rx_sig_det_in = 1'b1;
		@(negedge clk_sys);
		check("driver idle", 1'b0, tx_drv_oe);
		check("detect", 1'b1, rx_sig_det);
		tx_elec_idle = 1'b0;
		@(negedge clk_sys);
		check("driver on", 1'b1, tx_drv_oe);
		$display("test line done");
	endtask : t_line
	task automatic run(input int cyc, inout int del, inout int ins);
		repeat (cyc) begin
			@(negedge clk_sys);
			del += (rx_rm_deleted === 1'b1);
			ins += (rx_rm_inserted === 1'b1);
		end
	endtask : run
	// Cases: unsynced, idle sets, config pairs in and out of autoneg,
	// then matching switched off outside the Ethernet mode
	task automatic t_rm;
		logic [4:0] e_del;
		int del, ins;
		e_del = 5'h06;
		for (int i = 0; i < 5; i++) begin
			cfg_gige = (i != 4);
			rx_sync_status = (i != 0);
			rx_autoneg = (i == 2);
			sec = (i < 2) ? D16_2 : D2_2;
			del = 0;
			ins = 0;
			sink_stall = 1'b1;
			mode = 2'h1;
			run(200, del, ins);
			check("refused", !e_del[i], !rx_in_ready);
			check("deletes", e_del[i], del > 0);
			sink_stall = 1'b0;
			mode = 2'h2;
			ins = 0;
			run(300, del, ins);
			mode = 2'h0;
			run(20, del, ins);
			// Flags settled here; a pulse cut at a window end looks odd
			check("delete even", 1'b0, del % 2);
			check("inserts", i == 1 || i == 2, ins > 0);
			check("insert even", 1'b0, ins % 2);
		end
		check("pair errors", 10'h0000, 10'(pair_errs));
		$display("test rate match done");
	endtask : t_rm
	// Second reset into bypass: raw word straight out, detect off
	task automatic t_bypass;
		rst_b = 1'b0;
		cfg_low_latency = 1'b1;
		tx_raw = 10'h02A5;
		@(negedge clk_sys);
		rst_b = 1'b1;
		@(negedge clk_sys);
		check("raw out", 10'h02A5, tx_code);
		check("detect off", 1'b0, rx_sig_det);
		$display("test bypass done");
	endtask : t_bypass
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	// Whole run needs about 2700 cycles; cut off well beyond
	initial begin
		#250000;
		num_errors++;
		conclude();
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		t_sync();
		t_disp();
		t_line();
		t_rm();
		t_bypass();
		conclude();
	end
endmodule : spcs_pcs_top_bench
